// file: hdl/orc_pkg.sv
// orc_pkg: register map, field positions and reset values for the
// remote command register set; assumes 32-bit apb with word-aligned access
package orc_pkg;
  // ----------------------------------------
  // register indices, byte address = 4 * index
  // ----------------------------------------
  localparam logic [7:0] IDX_CMD_ISSUE    = 8'h42;
  localparam logic [7:0] IDX_RC_CONTROL   = 8'h4a;
  localparam logic [7:0] IDX_RC_ADDR_BYTE = 8'h4b;
  localparam logic [7:0] IDX_RC_DATA_BYTE = 8'h4c;
  localparam logic [7:0] IDX_MODEL_0      = 8'h55;
  localparam logic [7:0] IDX_MODEL_1      = 8'h56;
  localparam logic [7:0] IDX_MODEL_2      = 8'h57;
  localparam int         IDX_LSB          = 2;
  localparam int         IDX_MSB          = 9;
  localparam int         ADDR_W           = 10;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int POS_MODE_LOW   = 0;
  localparam int POS_MODE_HIGH  = 1;
  localparam int POS_CODE_LOW   = 2;
  localparam int POS_CODE_HIGH  = 3;
  localparam int POS_CAP_LOW    = 4;
  localparam int POS_CAP_HIGH   = 5;
  localparam int POS_READ_ACK   = 6;
  localparam int POS_RSVD       = 7;
  localparam logic [7:0] CTRL_WR_MASK = 8'hcf;
  localparam logic [7:0] CTRL_RESET   = 8'h22;
  localparam logic [1:0] MODE_NORMAL  = 2'h0;
  localparam logic [1:0] MODE_EXTEND  = 2'h2;

  // issue register fields
  localparam int POS_ISSUE = 0;
  localparam int POS_BUSY  = 1;

  // ----------------------------------------
  // reset values of byte registers
  // ----------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // command kinds: {read_ack, op_code}
  typedef enum logic [2:0]
  {
    ORC_READ_REPLY    = 3'h0,
    ORC_READ_REQUEST  = 3'h1,
    ORC_WRITE_REPLY   = 3'h2,
    ORC_WRITE_REQUEST = 3'h3,
    ORC_READ_ACK      = 3'h5,
    ORC_NONE          = 3'h7
  } orc_kind_t;

  // issue sequencer, one-hot
  typedef enum logic [1:0]
  {
    ORC_IDLE = 2'b01,
    ORC_SEND = 2'b10
  } orc_state_t;
endpackage : orc_pkg

// file: hdl/orc_regs.sv
// orc_regs: apb register set that builds bits 24..47 of the outgoing
// maintenance frame; assumes a frame transmitter on the same clock
// that takes frame_start and answers with frame_done.
// assumes an apb master on clk; reads are answered from a word latched
// in the setup cycle, so no wait state is ever inserted.
//
// Summary of operation
// - extended mode: two code bits pick read/write reply or request
// - mode 00: frame bits 24..47 come from model-information registers
// - mode 10: frame bits 24..47 come from remote command registers
// - mode field resets to 10, code bits reset to 00
// - issued command puts address byte into frame bits 39..32
// - issued command puts data byte into frame bits 47..40
// - address and data byte registers are read-write, reset zero
// - read_ack with code 01: 001 read request, 101 read ack
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module orc_regs
(
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [orc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        frame_done,
  output logic                             frame_start,
  output logic      [23:0]                 frame_model_info_bits,
  output logic      [2:0]                  frame_command_kind
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction : hit

  // unmapped indices answer with an error and read as zero
  function automatic logic is_mapped(input logic [7:0] idx);
    case (idx)
      orc_pkg::IDX_CMD_ISSUE,
      orc_pkg::IDX_RC_CONTROL,
      orc_pkg::IDX_RC_ADDR_BYTE,
      orc_pkg::IDX_RC_DATA_BYTE,
      orc_pkg::IDX_MODEL_0,
      orc_pkg::IDX_MODEL_1,
      orc_pkg::IDX_MODEL_2:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  wire logic [7:0] idx    = paddr[orc_pkg::IDX_MSB:orc_pkg::IDX_LSB];
  wire logic       access = psel & penable;
  wire logic       wr_en  = access & pwrite;

  wire logic sel_issue = hit(idx, orc_pkg::IDX_CMD_ISSUE);
  wire logic sel_ctrl  = hit(idx, orc_pkg::IDX_RC_CONTROL);
  wire logic sel_addr  = hit(idx, orc_pkg::IDX_RC_ADDR_BYTE);
  wire logic sel_data  = hit(idx, orc_pkg::IDX_RC_DATA_BYTE);
  wire logic sel_m0    = hit(idx, orc_pkg::IDX_MODEL_0);
  wire logic sel_m1    = hit(idx, orc_pkg::IDX_MODEL_1);
  wire logic sel_m2    = hit(idx, orc_pkg::IDX_MODEL_2);
  wire logic mapped    = is_mapped(idx);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]          ctrl_q;
  logic [7:0]          addr_byte_q;
  logic [7:0]          data_byte_q;
  logic [7:0]          model0_q;
  logic [7:0]          model1_q;
  logic [7:0]          model2_q;
  orc_pkg::orc_state_t state_q;
  orc_pkg::orc_state_t state_d;
  logic [23:0]         frame_q;
  logic [2:0]          kind_q;

  // capability bits are read-only, the rest writable
  wire logic [7:0] ctrl_d = (pwdata[7:0] & orc_pkg::CTRL_WR_MASK)
                          | (ctrl_q & ~orc_pkg::CTRL_WR_MASK);

  // ----------------------------------------
  // next values of plain bytes
  // ----------------------------------------
  function automatic logic [7:0] rw_next
  (
    input logic [7:0] cur,
    input logic       take,
    input logic [7:0] wd
  );
    rw_next = take ? wd : cur;
  endfunction : rw_next

  wire logic [7:0] addr_byte_d = rw_next(addr_byte_q, wr_en && sel_addr, pwdata[7:0]);
  wire logic [7:0] data_byte_d = rw_next(data_byte_q, wr_en && sel_data, pwdata[7:0]);
  wire logic [7:0] model0_d    = rw_next(model0_q, wr_en && sel_m0, pwdata[7:0]);
  wire logic [7:0] model1_d    = rw_next(model1_q, wr_en && sel_m1, pwdata[7:0]);
  wire logic [7:0] model2_d    = rw_next(model2_q, wr_en && sel_m2, pwdata[7:0]);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ctrl_q <= orc_pkg::CTRL_RESET;
    else if (wr_en && sel_ctrl)
      ctrl_q <= ctrl_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      addr_byte_q <= orc_pkg::BYTE_RESET;
    else
      addr_byte_q <= addr_byte_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      data_byte_q <= orc_pkg::BYTE_RESET;
    else
      data_byte_q <= data_byte_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      model0_q <= orc_pkg::BYTE_RESET;
    else
      model0_q <= model0_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      model1_q <= orc_pkg::BYTE_RESET;
    else
      model1_q <= model1_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      model2_q <= orc_pkg::BYTE_RESET;
    else
      model2_q <= model2_d;
  end

  // ----------------------------------------
  // frame content selection
  // ----------------------------------------
  wire logic [1:0] op_mode   = {ctrl_q[orc_pkg::POS_MODE_HIGH],
                                ctrl_q[orc_pkg::POS_MODE_LOW]};
  wire logic [1:0] op_code   = {ctrl_q[orc_pkg::POS_CODE_HIGH],
                                ctrl_q[orc_pkg::POS_CODE_LOW]};
  wire logic       read_ack  = ctrl_q[orc_pkg::POS_READ_ACK];
  // reserved modes 01 and 11 fall back to model info, the safe choice
  wire logic       extended  = (op_mode == orc_pkg::MODE_EXTEND);

  wire logic [23:0] model_bits = {model2_q, model1_q, model0_q};
  wire logic [23:0] cmd_bits   = {data_byte_q, addr_byte_q, ctrl_q};
  wire logic [23:0] frame_sel  = extended ? cmd_bits : model_bits;

  // read ack only pairs with code 01
  function automatic logic [2:0] kind_of(input logic ack, input logic [1:0] code);
    case ({ack, code})
      3'h0:    kind_of = orc_pkg::ORC_READ_REPLY;
      3'h1:    kind_of = orc_pkg::ORC_READ_REQUEST;
      3'h2:    kind_of = orc_pkg::ORC_WRITE_REPLY;
      3'h3:    kind_of = orc_pkg::ORC_WRITE_REQUEST;
      3'h5:    kind_of = orc_pkg::ORC_READ_ACK;
      default: kind_of = orc_pkg::ORC_NONE;
    endcase
  endfunction : kind_of

  // normal and reserved modes carry no command
  wire logic [2:0] kind_sel  = extended ? kind_of(read_ack, op_code) : orc_pkg::ORC_NONE;

  // ----------------------------------------
  // issue sequencer
  // ----------------------------------------
  wire logic issue_req = wr_en && sel_issue && pwdata[orc_pkg::POS_ISSUE];
  wire logic busy      = (state_q == orc_pkg::ORC_SEND);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      orc_pkg::ORC_IDLE:
        if (issue_req)
          state_d = orc_pkg::ORC_SEND;
      orc_pkg::ORC_SEND:
        if (frame_done)
          state_d = orc_pkg::ORC_IDLE;
      default:
        state_d = orc_pkg::ORC_IDLE;
    endcase
  end

  wire logic        take_issue = issue_req && !busy;
  // contents frozen at issue so software edits cannot tear a frame
  wire logic [23:0] frame_d    = take_issue ? frame_sel : frame_q;
  wire logic [2:0]  kind_d     = take_issue ? kind_sel : kind_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= orc_pkg::ORC_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      frame_q <= 24'h0000_00;
      kind_q  <= orc_pkg::ORC_NONE;
    end
    else
    begin
      frame_q <= frame_d;
      kind_q  <= kind_d;
    end
  end

  // ----------------------------------------
  // frame handshake
  // ----------------------------------------
  logic start_q;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      start_q <= 1'b0;
    else
      start_q <= take_issue;
  end

  assign frame_start           = start_q;
  assign frame_model_info_bits = frame_q;
  assign frame_command_kind    = kind_q;

  // ----------------------------------------
  // read data and answer
  // ----------------------------------------
  wire logic [7:0] issue_rd = {6'h00, busy, 1'b0};
  wire logic [7:0] rd_byte  = sel_issue ? issue_rd
                            : sel_ctrl  ? ctrl_q
                            : sel_addr  ? addr_byte_q
                            : sel_data  ? data_byte_q
                            : sel_m0    ? model0_q
                            : sel_m1    ? model1_q
                            : sel_m2    ? model2_q
                            : 8'h00;

  logic [31:0] prdata_q;

  // word latched in the setup cycle and held through the access cycle;
  // the busy flag can therefore read one cycle late
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_q <= {24'h0000_00, rd_byte};
  end

  assign prdata  = prdata_q;
  // zero wait states
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

endmodule : orc_regs

// file: sim/orc_frame_tx.sv
// orc_frame_tx: frame transmitter model that ends each send with frame_done
// assumes the same clock and reset as the register set
`timescale 1ns/1ps
module orc_frame_tx
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic frame_start,
  input  wire logic slow,
  output logic      frame_done
);
  logic [3:0] cnt_q;
  // slow sends keep busy up long enough to try a second issue
  always_ff @(posedge clk)
  begin
    frame_done <= 1'b0;
    if (!rst_n)
      cnt_q <= 4'h0;
    else if (frame_start)
      cnt_q <= slow ? 4'h9 : 4'h1;
    else if (cnt_q != 4'h0)
    begin
      cnt_q <= cnt_q - 4'h1;
      frame_done <= (cnt_q == 4'h1);
    end
  end
endmodule : orc_frame_tx

// file: sim/orc_regs_chk.sv
// orc_regs_chk: port assertions for the remote command register set
// assumes it is bound into orc_regs and sees only its ports
`timescale 1ns/1ps
module orc_regs_chk
(
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [orc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       frame_done,
  input wire logic                       frame_start,
  input wire logic [23:0]                frame_model_info_bits,
  input wire logic [2:0]                 frame_command_kind
);
  wire       acc  = psel && penable;
  wire [7:0] idx  = paddr[9:2];
  wire       iss  = acc && pwrite && idx == 8'h42 && pwdata[0];
  wire       ok   = idx == 8'h42 || (idx >= 8'h4a && idx <= 8'h4c) || (idx >= 8'h55 && idx <= 8'h57);
  logic      busy_q;
  logic      take;
  logic [1:0] mode_q;
  logic [7:0] cb;
  assign take = iss && !busy_q;
  assign cb = frame_model_info_bits[7:0];
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      mode_q <= 2'h2;
    end
    else
    begin
      busy_q <= take || (busy_q && !frame_done);
      if (acc && pwrite && idx == 8'h4a)
        mode_q <= pwdata[1:0];
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_pulse; frame_start ##1 !frame_start; endsequence
  sequence s_ext; frame_start && mode_q == 2'h2; endsequence
  ready_a: assert property (acc |-> pready) else $error("no ready in access");
  err_a: assert property (acc |-> pslverr == !ok) else $error("bad error flag");
  upper_a: assert property (psel |-> prdata[31:8] == 24'h00_0000) else $error("upper bits");
  start_a: assert property (take |=> s_pulse) else $error("issue lost");
  refuse_a: assert property (iss && busy_q |=> !frame_start) else $error("busy issue");
  cause_a: assert property (frame_start |-> $past(take)) else $error("stray start");
  hold_a: assert property (!frame_start |-> $stable(frame_model_info_bits)) else $error("hold");
  mode_a: assert property (frame_start && mode_q != 2'h2 |-> frame_command_kind == 3'h7)
    else $error("kind in normal mode");
  code_a: assert property (s_ext ##0 !cb[6] |-> frame_command_kind == {1'b0, cb[3:2]})
    else $error("code kind");
  ack_a: assert property (s_ext ##0 cb[6] |-> frame_command_kind == (cb[3:2] == 2'h1 ? 3'h5 : 3'h7))
    else $error("ack kind");
endmodule : orc_regs_chk
bind orc_regs orc_regs_chk orc_regs_chk_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .frame_done(frame_done), .frame_start(frame_start),
  .frame_model_info_bits(frame_model_info_bits), .frame_command_kind(frame_command_kind));

// file: sim/orc_regs_bench.sv
// orc_regs_bench: random and corner tests of the remote command register set
// assumes orc_regs plus the frame transmitter model on one clock
`timescale 1ns/1ps
module orc_regs_bench;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic        pready, pslverr, frame_done, frame_start, slv;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [23:0] bits;
  logic [2:0]  kind;
  logic [7:0]  v [6];
  logic [7:0]  ix [6] = '{8'h4a, 8'h4b, 8'h4c, 8'h55, 8'h56, 8'h57};
  int          seed = 83748, failures = 0, n_tests = 0, k;
  always #25 clk = ~clk;
  orc_regs orc_regs_inst (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_done(frame_done), .frame_start(frame_start),
    .frame_model_info_bits(bits), .frame_command_kind(kind));
  orc_frame_tx orc_frame_tx_inst (.clk(clk), .rst_n(rst_n), .frame_start(frame_start),
    .slow(slow), .frame_done(frame_done));
  function automatic logic [7:0] rb(input logic [7:0] c);
    return (c & 8'hcf) | 8'h20;
  endfunction : rb
  function automatic logic [26:0] exp_frame(input logic [7:0] c);
    if (c[1:0] != 2'h2)
      return {3'h7, v[5], v[4], v[3]};
    return {c[6] ? (c[3:2] == 2'h1 ? 3'h5 : 3'h7) : {1'b0, c[3:2]}, v[2], v[1], rb(c)};
  endfunction : exp_frame
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tmo;
    failures++;
    $display("CHECK FAILED %0t wait ran out", $time);
    results;
  endtask : tmo
  task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (k >= 16)
      tmo;
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task fire(input logic ok);
    apb(1'b1, 8'h42, 8'h01);
    @(negedge clk);
    chk({31'h0, frame_start}, {31'h0, ok});
    chk({5'h0, kind, bits}, {5'h0, exp_frame(v[0])});
  endtask : fire
  task idle;
    rd = 32'h0000_0002;
    for (int j = 0; j < 40 && rd[1]; j++)
      apb(1'b0, 8'h42, 8'h00);
    if (rd[1] !== 1'b0)
      tmo;
  endtask : idle
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, ix[i], 8'h00);
      chk(rd, i == 0 ? 32'h0000_0022 : 32'h0000_0000);
      v[i] = 8'($random(seed));
      apb(1'b1, ix[i], v[i]);
      apb(1'b0, ix[i], 8'h00);
      chk(rd, {24'h00_0000, i == 0 ? rb(v[i]) : v[i]});
    end
    apb(1'b1, 8'h4d, 8'hff);
    apb(1'b0, 8'h4d, 8'h00);
    chk({rd[30:0], slv}, 32'h0000_0001);
    // every mode, code and read_ack setting, host loads the bytes
    for (int n = 0; n < 32; n++)
    begin
      for (int i = 0; i < 6; i++)
      begin
        v[i] = i == 0 ? {1'b0, n[0], 2'h0, n[2:1], n[4:3]} : 8'($random(seed));
        apb(1'b1, ix[i], v[i]);
      end
      slow <= n[0];
      fire(1'b1);
      idle;
    end
    // second issue during a slow send is dropped
    slow <= 1'b1;
    v[0] = 8'h06;
    apb(1'b1, 8'h4a, v[0]);
    fire(1'b1);
    apb(1'b1, 8'h4b, ~v[1]);
    fire(1'b0);
    idle;
    results;
  end
endmodule : orc_regs_bench
